// ---- inc/erl_consts.svh ----
`ifndef ERL_CONSTS_SVH
`define ERL_CONSTS_SVH
// register byte offsets
`define ERL_OFS_PORT_TYPE 8'h00
`define ERL_OFS_RATE_EN 8'h04
`define ERL_OFS_DFLT_BASE 8'h10
`define ERL_OFS_TOT_BASE 8'h20
`define ERL_OFS_RDROP_BASE 8'h30
`define ERL_OFS_EVENT 8'h40
`define ERL_OFS_MASK 8'h44
`define ERL_OFS_RATE_BASE 8'h80
// port type register: one byte lane per port
`define ERL_PT_LANE_W 8
`define ERL_PT_INSERT 2
`define ERL_PT_CHG_TAG 3
`define ERL_PT_CHG_VID 4
`define ERL_PT_CHG_PRI 5
// default vid / priority register fields
`define ERL_DF_VID_LSB 0
`define ERL_DF_PRI_LSB 12
// reset values
`define ERL_RST_PORT_TYPE 32'h0000_0000
`define ERL_RST_RATE_EN 12'h000
`define ERL_RST_RATE 13'h0000
`define ERL_RST_DFLT 15'h0001
`define ERL_RST_MASK 6'h00
// timing: per-byte step and clock period in ns
`define ERL_BYTE_STEP_NS 20
`define ERL_CLK_NS 10
`define ERL_STEP_CYC (`ERL_BYTE_STEP_NS / `ERL_CLK_NS)
// settings at or below this give the same minimum delay
`define ERL_MIN_SETTING 13'h0003
`endif

// ---- inc/erl_pkg.sv ----
package erl_pkg;
	// egress port behaviour, encoded 0..3 (cpu is 11b)
	typedef enum logic [1:0] {PT_DUMB, PT_ACCESS, PT_HYBRID, PT_CPU} erl_port_type_t;
	// received packet tag class
	typedef enum logic [1:0] {RX_UNTAGGED, RX_PRIO, RX_NORMAL, RX_SPECIAL} erl_rx_kind_t;
	// tag edit result
	typedef enum logic [2:0] {ACT_PASS, ACT_STRIP, ACT_INSERT, ACT_MODIFY, ACT_ADD_SPECIAL} erl_tag_act_t;
	// scheduler pick of one packet
	typedef struct packed {
		logic valid;
		logic [1:0] port;
		logic [1:0] queue;
		logic [10:0] len;
	} erl_sel_t;
	// tag edit request from the lookup stage
	typedef struct packed {
		logic valid;
		erl_rx_kind_t kind;
		logic [1:0] in_port;
		logic [1:0] out_port;
		logic [11:0] vlan_identifier;
		logic [2:0] pri;
		logic [2:0] untag_pkt;
		logic [2:0] untag_dflt;
	} erl_tag_req_t;
	// tag edit answer to the transmit side
	typedef struct packed {
		logic valid;
		erl_tag_act_t act;
		logic [11:0] vlan_identifier;
		logic [2:0] pri;
		logic keep_inner;
	} erl_tag_res_t;
	// packet drop report
	typedef struct packed {
		logic valid;
		logic [1:0] port;
		logic rate;
	} erl_drop_t;
endpackage

// ---- hdl/erl_egress.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "erl_consts.svh"

//
// Overview of operation
// - leaky bucket on every port queue
// - held queues keep packets upstream in memory
// - limited queues masked before priority selection
// - per queue enable; disabled never held
// - block queue for length times per-byte delay
// - per-byte delay in 20 ns steps
// - settings up to 39 unlimited at 10M
// - classify four rx kinds, four port types
// - dumb port passes, strips special tag
// - access port strips all tags
// - cpu port adds source special tag
// - special tag vid bits 1:0 source
// - existing vlan tag kept after special
// - untag bit picked by ingress port
// - hybrid untagged: insert with ingress defaults
// - hybrid priority tag: strip or retag
// - hybrid normal tag: strip, pass or modify
// - hybrid normal modify with egress defaults, strip special
// - per port default vid and priority
// - per source count all drops
// - per source count rate drops only
// - maskable drop event interrupt
module erl_egress
	import erl_pkg::*;
#(
	parameter int NPORT = 3,
	parameter int NQ = 4,
	parameter int CNT_W = 26
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [11:0] queue_pending,
	output logic [11:0] queue_eligible,
	input wire erl_sel_t sel_in,
	input wire erl_tag_req_t tag_req,
	output erl_tag_res_t tag_res,
	input wire erl_drop_t drop_in,
	output logic irq
);

	// ****************************************
	// bus decode
	// ****************************************

	logic bus_setup; // first cycle of a transfer
	logic bus_wr; // write takes effect in access phase
	logic [31:0] rd_nxt; // read mux
	logic hit_nxt; // address is mapped
	logic [31:0] rd_r; // registered read data
	logic err_r; // registered error

	assign bus_setup = psel && !penable;
	assign bus_wr = psel && penable && pwrite && !err_r;
	// zero wait states: answer was prepared during setup
	assign pready = 1'b1;
	assign prdata = rd_r;
	assign pslverr = err_r;

	// byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// ****************************************
	// configuration registers
	// ****************************************

	logic [31:0] ptype_r; // per-port egress type and edit bits
	logic [11:0] rate_en_r; // limiter enable, index port*4+queue
	logic [12:0] rate_set_r [0:11]; // per queue delay setting
	logic [14:0] dflt_r [0:2]; // default vid and priority per port
	logic [31:0] tot_cnt_r [0:2]; // all drops per source
	logic [31:0] rdrop_cnt_r [0:2]; // rate drops per source
	logic [5:0] evt_r; // sticky drop events
	logic [5:0] mask_r; // event enables

	// port type and edit bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptype_r <= `ERL_RST_PORT_TYPE;
		end else if (bus_wr && paddr == `ERL_OFS_PORT_TYPE) begin
			ptype_r <= merge(ptype_r, pwdata, pstrb);
		end
	end

	// limiter enables, one bit per queue
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_en_r <= `ERL_RST_RATE_EN;
		end else if (bus_wr && paddr == `ERL_OFS_RATE_EN) begin
			rate_en_r <= 12'(merge({20'h0, rate_en_r}, pwdata, pstrb));
		end
	end

	// event mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= `ERL_RST_MASK;
		end else if (bus_wr && paddr == `ERL_OFS_MASK && pstrb[0]) begin
			mask_r <= pwdata[5:0];
		end
	end

	// default vid/priority, one register per port
	for (genvar p = 0; p < NPORT; p++) begin : g_dflt
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dflt_r[p] <= `ERL_RST_DFLT;
			end else if (bus_wr && paddr == (`ERL_OFS_DFLT_BASE + 8'(p * 4))) begin
				dflt_r[p] <= 15'(merge({17'h0, dflt_r[p]}, pwdata, pstrb));
			end
		end
	end

	// ****************************************
	// drop counters and events
	// ****************************************

	// counters only ever move on a drop report; reads leave them alone
	for (genvar p = 0; p < NPORT; p++) begin : g_cnt
		logic hit; // report belongs to this source
		assign hit = drop_in.valid && drop_in.port == 2'(p);
		// every drop, buffer or rate
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tot_cnt_r[p] <= 32'h0;
			end else if (hit) begin
				tot_cnt_r[p] <= tot_cnt_r[p] + 32'h1;
			end
		end
		// rate drops alone, so software can subtract
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rdrop_cnt_r[p] <= 32'h0;
			end else if (hit && drop_in.rate) begin
				rdrop_cnt_r[p] <= rdrop_cnt_r[p] + 32'h1;
			end
		end
		// sticky flags: a new drop wins over a same-cycle clear
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				evt_r[p] <= 1'b0;
				evt_r[p+3] <= 1'b0;
			end else begin
				if (hit) begin
					evt_r[p] <= 1'b1;
				end else if (bus_wr && paddr == `ERL_OFS_EVENT && pstrb[0] && pwdata[p]) begin
					evt_r[p] <= 1'b0;
				end
				if (hit && drop_in.rate) begin
					evt_r[p+3] <= 1'b1;
				end else if (bus_wr && paddr == `ERL_OFS_EVENT && pstrb[0] && pwdata[p+3]) begin
					evt_r[p+3] <= 1'b0;
				end
			end
		end
	end

	// one level output from masked events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt_r & mask_r);
		end
	end

	// ****************************************
	// egress leaky buckets
	// ****************************************

	logic [11:0] blocked; // queue waits out its byte time

	// one bucket per port queue; the pick only blocks the queue later on,
	// packets meanwhile stay queued in packet memory upstream
	for (genvar i = 0; i < NPORT * NQ; i++) begin : g_bucket
		logic [CNT_W-1:0] wait_r; // cycles left before re-service
		logic [12:0] eff; // setting clamped to the minimum
		logic [CNT_W-1:0] load; // length times per-byte cycles
		logic pick; // this queue was just chosen
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rate_set_r[i] <= `ERL_RST_RATE;
			end else if (bus_wr && paddr == (`ERL_OFS_RATE_BASE + 8'(i * 4))) begin
				rate_set_r[i] <= 13'(merge({19'h0, rate_set_r[i]}, pwdata, pstrb));
			end
		end
		assign pick = sel_in.valid && {sel_in.port, sel_in.queue} == 4'(i);
		// settings 0..3 all give 80 ns per byte
		assign eff = (rate_set_r[i] < `ERL_MIN_SETTING) ? `ERL_MIN_SETTING : rate_set_r[i];
		// no overflow: 2047 bytes * 8192 * 2 stays under 2^25; the +1 is
		// done at counter width so the top setting does not wrap to zero
		assign load = CNT_W'(sel_in.len) * (CNT_W'(eff) + CNT_W'(1))
			* CNT_W'(`ERL_STEP_CYC);
		// a queue without its enable is never loaded
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				wait_r <= '0;
			end else if (pick && rate_en_r[i]) begin
				wait_r <= load;
			end else if (wait_r != '0) begin
				wait_r <= wait_r - CNT_W'(1);
			end
		end
		// long settings simply stretch the wait beyond line byte time
		assign blocked[i] = rate_en_r[i] && wait_r != '0;
	end

	// masking before selection lets a lower queue go while a higher waits
	assign queue_eligible = queue_pending & ~blocked;

	// ****************************************
	// vlan tag editor
	// ****************************************

	erl_tag_res_t res_nxt; // edit decision for the current request
	erl_port_type_t out_type; // egress port behaviour
	logic [7:0] lane; // egress port edit byte
	logic [1:0] ip; // ingress port, clamped
	logic [1:0] op; // egress port, clamped
	logic ut_pkt; // untag bit of packet vid entry
	logic ut_dflt; // untag bit of default vid entry
	logic [11:0] in_vid; // ingress default vid
	logic [2:0] in_pri; // ingress default priority
	logic [11:0] eg_vid; // egress default vid
	logic [2:0] eg_pri; // egress default priority

	// an unused port number 3 falls back to port 0
	assign ip = (tag_req.in_port < 2'd3) ? tag_req.in_port : 2'd0;
	assign op = (tag_req.out_port < 2'd3) ? tag_req.out_port : 2'd0;
	assign lane = ptype_r[op*`ERL_PT_LANE_W +: `ERL_PT_LANE_W];
	assign out_type = erl_port_type_t'(lane[1:0]);
	assign ut_pkt = tag_req.untag_pkt[ip];
	assign ut_dflt = tag_req.untag_dflt[ip];
	assign in_vid = dflt_r[ip][`ERL_DF_VID_LSB +: 12];
	assign in_pri = dflt_r[ip][`ERL_DF_PRI_LSB +: 3];
	assign eg_vid = dflt_r[op][`ERL_DF_VID_LSB +: 12];
	assign eg_pri = dflt_r[op][`ERL_DF_PRI_LSB +: 3];

	// decision by egress type, then by received kind
	always_comb begin
		res_nxt.valid = tag_req.valid;
		res_nxt.act = ACT_PASS;
		res_nxt.vlan_identifier = tag_req.vlan_identifier;
		res_nxt.pri = tag_req.pri;
		res_nxt.keep_inner = 1'b0;
		case (out_type)
			PT_DUMB: begin
				// only the special tag is removed
				if (tag_req.kind == RX_SPECIAL) begin
					res_nxt.act = ACT_STRIP;
				end
			end
			PT_ACCESS: begin
				// untagged passes, any tag goes
				if (tag_req.kind != RX_UNTAGGED) begin
					res_nxt.act = ACT_STRIP;
				end
			end
			PT_CPU: begin
				// a fresh special tag replaces any arriving special tag
				res_nxt.act = ACT_ADD_SPECIAL;
				res_nxt.vlan_identifier = {10'h000, ip};
				res_nxt.pri = (tag_req.kind == RX_UNTAGGED) ? in_pri : tag_req.pri;
				res_nxt.keep_inner = (tag_req.kind == RX_PRIO)
					|| (tag_req.kind == RX_NORMAL);
			end
			PT_HYBRID: begin
				case (tag_req.kind)
					RX_UNTAGGED: begin
						if (lane[`ERL_PT_INSERT] && !ut_dflt) begin
							res_nxt.act = ACT_INSERT;
							res_nxt.vlan_identifier = in_vid;
							res_nxt.pri = in_pri;
						end
					end
					RX_PRIO: begin
						if (ut_dflt) begin
							res_nxt.act = ACT_STRIP;
						end else begin
							res_nxt.act = ACT_MODIFY;
							res_nxt.vlan_identifier = in_vid;
							if (lane[`ERL_PT_CHG_PRI]) begin
								res_nxt.pri = in_pri;
							end
						end
					end
					RX_NORMAL: begin
						if (ut_pkt) begin
							res_nxt.act = ACT_STRIP;
						end else if (!lane[`ERL_PT_CHG_TAG]) begin
							res_nxt.act = ACT_PASS;
						end else if (!lane[`ERL_PT_CHG_VID] && !lane[`ERL_PT_CHG_PRI]) begin
							res_nxt.act = ACT_PASS;
						end else begin
							res_nxt.act = ACT_MODIFY;
							if (lane[`ERL_PT_CHG_VID]) begin
								res_nxt.vlan_identifier = eg_vid;
							end
							if (lane[`ERL_PT_CHG_PRI]) begin
								res_nxt.pri = eg_pri;
							end
						end
					end
					default: begin
						res_nxt.act = ACT_STRIP;
					end
				endcase
			end
			default: begin
				res_nxt.act = ACT_PASS;
			end
		endcase
	end

	// one-cycle registered answer per request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tag_res <= '0;
		end else begin
			tag_res <= res_nxt;
		end
	end

	// ****************************************
	// read path
	// ****************************************

	// word index for the banked registers
	logic [5:0] widx;
	assign widx = paddr[7:2];

	// read mux; also flags unmapped and misaligned addresses
	always_comb begin
		rd_nxt = 32'h0;
		hit_nxt = 1'b0;
		if (paddr[1:0] == 2'b00) begin
			if (paddr == `ERL_OFS_PORT_TYPE) begin
				rd_nxt = ptype_r;
				hit_nxt = 1'b1;
			end else if (paddr == `ERL_OFS_RATE_EN) begin
				rd_nxt = {20'h0, rate_en_r};
				hit_nxt = 1'b1;
			end else if (paddr == `ERL_OFS_EVENT) begin
				rd_nxt = {26'h0, evt_r};
				hit_nxt = 1'b1;
			end else if (paddr == `ERL_OFS_MASK) begin
				rd_nxt = {26'h0, mask_r};
				hit_nxt = 1'b1;
			end else if (paddr >= `ERL_OFS_RATE_BASE && widx < 6'h2c) begin
				rd_nxt = {19'h0, rate_set_r[4'(widx - 6'h20)]};
				hit_nxt = 1'b1;
			end else if (widx >= 6'h04 && widx < 6'h07) begin
				rd_nxt = {17'h0, dflt_r[2'(widx - 6'h04)]};
				hit_nxt = 1'b1;
			end else if (widx >= 6'h08 && widx < 6'h0b) begin
				rd_nxt = tot_cnt_r[2'(widx - 6'h08)];
				hit_nxt = 1'b1;
			end else if (widx >= 6'h0c && widx < 6'h0f) begin
				rd_nxt = rdrop_cnt_r[2'(widx - 6'h0c)];
				hit_nxt = 1'b1;
			end
		end
	end

	// answer captured in setup; counters are read-only, writes there err
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_r <= 32'h0;
			err_r <= 1'b0;
		end else if (bus_setup) begin
			rd_r <= pwrite ? 32'h0 : rd_nxt;
			err_r <= !hit_nxt || (pwrite && widx >= 6'h08 && widx < 6'h0f);
		end
	end

endmodule
`default_nettype wire

// ---- testbench/erl_egress_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// egress port checks
// ****************
module erl_egress_chk
	import erl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic [11:0] queue_pending,
	input wire logic [11:0] queue_eligible,
	input wire erl_sel_t sel_in,
	input wire erl_tag_req_t tag_req,
	input wire erl_tag_res_t tag_res,
	input wire logic irq
);
	// one domain, so clock and reset are set once
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a queue is only eligible while something waits in it
	property p_elig_sub;
		(queue_eligible & ~queue_pending) == 12'h000;
	endproperty
	a_elig_sub: assert property (p_elig_sub) else $error("eligible queue not pending");
	// answer follows the request by one cycle
	property p_tag_lat;
		tag_res.valid == $past(tag_req.valid);
	endproperty
	a_tag_lat: assert property (p_tag_lat) else $error("tag answer late");
	// an arriving special tag never survives as it came
	property p_special_gone;
		tag_req.valid && tag_req.kind == RX_SPECIAL |=> tag_res.act inside {ACT_STRIP, ACT_ADD_SPECIAL};
	endproperty
	a_special_gone: assert property (p_special_gone) else $error("special tag kept");
	// no tag to strip or modify on an untagged packet
	property p_untag_kept;
		tag_req.valid && tag_req.kind == RX_UNTAGGED |=> !(tag_res.act inside {ACT_STRIP, ACT_MODIFY});
	endproperty
	a_untag_kept: assert property (p_untag_kept) else $error("untagged packet edited");
	// source port in the low vid bits, port 3 folds to 0
	property p_src_vid;
		tag_res.valid && tag_res.act == ACT_ADD_SPECIAL |-> tag_res.vlan_identifier ==
			{10'h000, ($past(tag_req.in_port) == 2'h3) ? 2'h0 : $past(tag_req.in_port)};
	endproperty
	a_src_vid: assert property (p_src_vid) else $error("special tag source wrong");
	// an existing vlan tag rides behind the special tag
	property p_inner;
		tag_res.valid && tag_res.act == ACT_ADD_SPECIAL && $past(tag_req.kind) inside {RX_PRIO, RX_NORMAL}
			|-> tag_res.keep_inner;
	endproperty
	a_inner: assert property (p_inner) else $error("inner tag lost");
	// insertion is only for untagged packets
	property p_insert_src;
		tag_res.valid && tag_res.act == ACT_INSERT |-> $past(tag_req.kind) == RX_UNTAGGED;
	endproperty
	a_insert_src: assert property (p_insert_src) else $error("insert on tagged packet");
	// a one byte pick blocks at least 8 cycles; a register write may release it
	property p_min_block(int i);
		sel_in.valid && {sel_in.port, sel_in.queue} == 4'(i) ##1 !queue_eligible[i] && queue_pending[i]
			&& !psel |=> (!queue_eligible[i] || !queue_pending[i] || psel || $past(psel))[*7];
	endproperty
	for (genvar i = 0; i < 12; i++) begin : g_q
		a_min_block: assert property (p_min_block(i)) else $error("queue released early");
	end
	// main scenarios
	c_special: cover property (tag_res.valid && tag_res.act == ACT_ADD_SPECIAL);
	c_modify: cover property (tag_res.valid && tag_res.act == ACT_MODIFY);
	c_insert: cover property (tag_res.valid && tag_res.act == ACT_INSERT);
	c_irq: cover property ($rose(irq));
endmodule
bind erl_egress erl_egress_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.queue_pending(queue_pending), .queue_eligible(queue_eligible), .sel_in(sel_in),
	.tag_req(tag_req), .tag_res(tag_res), .irq(irq));
`default_nettype wire

// ---- testbench/erl_sched_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// queue scheduler beside the egress stage
// ****************
module erl_sched_model
	import erl_pkg::*;
(
	input wire logic pclk,
	input wire logic [11:0] queue_pending,
	input wire logic [11:0] queue_eligible,
	output erl_sel_t sel_out
);
	initial sel_out = '0;
	// fixed priority pick of one port, q=4 when nothing may go
	task automatic pick(input logic [1:0] port, input logic [10:0] len, output logic [2:0] q);
		logic [3:0] b;
		@(posedge pclk);
		// levels seen at the edge are those of the cycle just ended
		b = queue_pending[port * 4 +: 4] & queue_eligible[port * 4 +: 4];
		q = 3'h4;
		for (int k = 0; k < 4; k++) begin
			if (b[k]) q = 3'(k);
		end
		if (q != 3'h4) sel_out <= '{1'b1, port, q[1:0], len};
		@(posedge pclk);
		// released fields go stale on purpose, not held
		sel_out <= '{1'b0, ~port, ~q[1:0], ~len};
	endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import erl_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0] pstrb;
	logic [11:0] queue_pending, queue_eligible;
	erl_sel_t sel_in;
	erl_tag_req_t tag_req;
	erl_tag_res_t tag_res;
	erl_drop_t drop_in;
	logic [7:0] pt_cfg [3];
	logic [11:0] dvid [3];
	logic [2:0] dpri [3];
	int n_fail, compares, cyc, lowcnt, tgt;
	int tot [3], rdc [3];
	erl_egress uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .queue_pending(queue_pending), .queue_eligible(queue_eligible),
		.sel_in(sel_in), .tag_req(tag_req), .tag_res(tag_res), .drop_in(drop_in), .irq(irq));
	erl_sched_model sched (.pclk(pclk), .queue_pending(queue_pending),
		.queue_eligible(queue_eligible), .sel_out(sel_in));
	// ****************
	// clock, watchdog, blocked cycle count
	// ****************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (queue_pending[tgt] && !queue_eligible[tgt]) lowcnt <= lowcnt + 1;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	// ****************
	// shared tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; waits for pready, result in rdat and rerr
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task results;
		if (n_fail == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// expected tag edit from the port setup shadow
	function automatic erl_tag_res_t exp_tag(erl_tag_req_t r);
		erl_tag_res_t e;
		logic [7:0] c;
		c = pt_cfg[r.out_port];
		e = '{1'b1, ACT_PASS, r.vlan_identifier, r.pri, 1'b0};
		case (c[1:0])
			2'h0: if (r.kind == RX_SPECIAL) e.act = ACT_STRIP;
			2'h1: if (r.kind != RX_UNTAGGED) e.act = ACT_STRIP;
			2'h3: begin
				e.act = ACT_ADD_SPECIAL;
				e.vlan_identifier = {10'h000, r.in_port};
				e.keep_inner = r.kind inside {RX_PRIO, RX_NORMAL};
				if (r.kind == RX_UNTAGGED) e.pri = dpri[r.in_port];
			end
			default: case (r.kind)
				RX_UNTAGGED: if (c[2] && !r.untag_dflt[r.in_port]) e = '{1'b1, ACT_INSERT,
					dvid[r.in_port], dpri[r.in_port], 1'b0};
				RX_PRIO: begin
					e.act = r.untag_dflt[r.in_port] ? ACT_STRIP : ACT_MODIFY;
					e.vlan_identifier = dvid[r.in_port];
					if (c[5]) e.pri = dpri[r.in_port];
				end
				RX_NORMAL: begin
					if (r.untag_pkt[r.in_port]) e.act = ACT_STRIP;
					else if (c[3] && (c[4] || c[5])) e.act = ACT_MODIFY;
					if (c[4]) e.vlan_identifier = dvid[r.out_port];
					if (c[5]) e.pri = dpri[r.out_port];
				end
				default: e.act = ACT_STRIP;
			endcase
		endcase
		return e;
	endfunction
	// ****************
	// main sequence
	// ****************
	initial begin
		erl_tag_req_t r;
		erl_tag_res_t e;
		erl_drop_t d;
		logic [12:0] s;
		logic [10:0] ln;
		logic [2:0] q;
		logic en;
		logic [5:0] ev;
		logic [7:0] ra [9];
		logic [12:0] stab [5];
		ra = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h20, 8'h30, 8'h44, 8'h80};
		stab = '{13'h0000, 13'h0003, 13'h0004, 13'h0027, 13'h0028};
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		queue_pending = 12'hfff;
		tag_req = '0;
		drop_in = '0;
		ev = '0;
		void'($urandom(9539));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, then refused accesses
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, ra[i], 32'h0);
			chk("reset value", rdat, (i >= 2 && i <= 4) ? 32'h1 : 32'h0);
		end
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped err", 32'(rerr), 32'h1);
		apb(1'b1, 8'h24, 32'h5);
		chk("counter write err", 32'(rerr), 32'h1);
		// one byte lane only: vid low byte keeps its reset value
		pstrb <= 4'h2;
		apb(1'b1, 8'h10, 32'hffff_ffff);
		pstrb <= 4'hf;
		apb(1'b0, 8'h10, 32'h0);
		chk("lane write", rdat, 32'h0000_7f01);
		// tag edits, every port type, back to back requests
		for (int cfg = 0; cfg < 8; cfg++) begin
			for (int p = 0; p < 3; p++) begin
				// cpu type only ever on port 0, the host side
				pt_cfg[p] = {2'h0, 4'($urandom), (p == 0) ? 2'(cfg) : 2'((cfg + p) % 3)};
				dvid[p] = 12'($urandom);
				dpri[p] = 3'($urandom);
				apb(1'b1, 8'h10 + 8'(4 * p), {17'h0, dpri[p], dvid[p]});
			end
			apb(1'b1, 8'h00, {8'h00, pt_cfg[2], pt_cfg[1], pt_cfg[0]});
			for (int k = 0; k <= 24; k++) begin
				@(posedge pclk);
				r = '{k < 24, erl_rx_kind_t'($urandom_range(0, 3)), 2'($urandom_range(0, 2)),
					2'($urandom_range(0, 2)), 12'($urandom), 3'($urandom), 3'($urandom), 3'($urandom)};
				tag_req <= r;
				queue_pending <= 12'($urandom);
				#1;
				if (k > 0) begin
					chk("tag action", 32'(tag_res.act), 32'(e.act));
					if (e.act inside {ACT_INSERT, ACT_MODIFY, ACT_ADD_SPECIAL}) begin
						chk("tag vid", 32'(tag_res.vlan_identifier), 32'(e.vlan_identifier));
						chk("tag pri", 32'(tag_res.pri), 32'(e.pri));
					end
					if (e.act == ACT_ADD_SPECIAL) chk("keep inner", 32'(tag_res.keep_inner), 32'(e.keep_inner));
				end
				e = exp_tag(r);
			end
		end
		// limiter: table corners then random settings
		queue_pending <= 12'hfff;
		for (int k = 0; k < 8; k++) begin
			s = (k < 5) ? stab[k] : 13'($urandom_range(0, 60));
			ln = 11'($urandom_range(1, 5));
			en = (k != 2);
			tgt = (k % 3) * 4 + 3;
			apb(1'b1, 8'h80 + 8'(4 * tgt), {19'h0, s});
			apb(1'b1, 8'h04, {20'h0, 12'(en) << tgt});
			lowcnt = 0;
			sched.pick(2'(k % 3), ln, q);
			chk("first pick", 32'(q), 32'h3);
			sched.pick(2'(k % 3), ln, q);
			chk("second pick", 32'(q), en ? 32'h2 : 32'h3);
			for (int w = 0; w < 2000 && queue_eligible[tgt] !== 1'b1; w++) @(posedge pclk);
			repeat (2) @(posedge pclk);
			chk("blocked cycles", lowcnt, en ? ln * ((s < 4) ? 4 : s + 1) * 2 : 0);
		end
		apb(1'b1, 8'h04, 32'h0);
		// drops, counters, events and irq
		apb(1'b1, 8'h44, 32'h3f);
		for (int k = 0; k < 60; k++) begin
			@(posedge pclk);
			d = '{1'($urandom), 2'($urandom_range(0, 2)), 1'($urandom)};
			drop_in <= d;
			if (d.valid) begin
				tot[d.port]++;
				ev[d.port] = 1'b1;
				if (d.rate) rdc[d.port]++;
				if (d.rate) ev[3 + d.port] = 1'b1;
			end
		end
		@(posedge pclk);
		drop_in <= '0;
		for (int p = 0; p < 3; p++) begin
			apb(1'b0, 8'h20 + 8'(4 * p), 32'h0);
			chk("total drops", rdat, tot[p]);
			apb(1'b0, 8'h30 + 8'(4 * p), 32'h0);
			chk("rate drops", rdat, rdc[p]);
			apb(1'b0, 8'h20 + 8'(4 * p), 32'h0);
			chk("total drops again", rdat, tot[p]);
		end
		apb(1'b0, 8'h40, 32'h0);
		chk("events", rdat, {26'h0, ev});
		chk("irq raised", 32'(irq), 32'(ev != 6'h00));
		apb(1'b1, 8'h40, 32'h3f);
		apb(1'b1, 8'h44, 32'h0);
		drop_in <= '{1'b1, 2'h1, 1'b1};
		@(posedge pclk);
		drop_in <= '0;
		repeat (3) @(posedge pclk);
		chk("irq masked", 32'(irq), 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("events after clear", rdat, 32'h0000_0012);
		results();
	end
endmodule
`default_nettype wire
